/* File: pkg/csq_consts.svh */
`ifndef CSQ_CONSTS_SVH
`define CSQ_CONSTS_SVH

// Clock and timer tick.
`define CSQ_CLK_PERIOD_NS 10
`define CSQ_TICK_US 1000
`define CSQ_PRESCALE_CYC (`CSQ_TICK_US * 1000 / `CSQ_CLK_PERIOD_NS)
`define CSQ_MIN_TICKS (60000000 / `CSQ_TICK_US)

// Phase durations; qualification is held in tenths of a minute.
`define CSQ_QUAL_TIME_DMIN 75
`define CSQ_FULL_TIME_MIN 90
`define CSQ_TOP_TIME_MIN 45
`define CSQ_FAST_TIME_MIN 90
`define CSQ_QUAL_TICKS (`CSQ_QUAL_TIME_DMIN * `CSQ_MIN_TICKS / 10)
`define CSQ_FULL_TICKS (`CSQ_FULL_TIME_MIN * `CSQ_MIN_TICKS)
`define CSQ_TOP_TICKS (`CSQ_TOP_TIME_MIN * `CSQ_MIN_TICKS)
`define CSQ_FAST_TICKS (`CSQ_FAST_TIME_MIN * `CSQ_MIN_TICKS)

// Temperature sampling rate in centihertz, and measurement window.
`define CSQ_TEMP_RATE_CHZ 112
`define CSQ_TEMP_PERIOD_TICKS \
  (100000000 / (`CSQ_TICK_US * `CSQ_TEMP_RATE_CHZ))
`define CSQ_TEMP_MEAS_TICKS 2

// Precharge current divider and programmed current reset value.
`define CSQ_PRECHG_DIV 10
`define CSQ_FAST_I_RST 8'hff

// Register byte offsets.
`define CSQ_ADDR_STATUS 5'h00
`define CSQ_ADDR_FAST_I 5'h04
`define CSQ_ADDR_LIM_QUAL 5'h08
`define CSQ_ADDR_LIM_FULL 5'h0c
`define CSQ_ADDR_LIM_TOP 5'h10
`define CSQ_ADDR_LIM_FAST 5'h14

// Status register field positions.
`define CSQ_ST_STATE_LSB 0
`define CSQ_ST_RESUME_LSB 4
`define CSQ_ST_IND_LSB 8
`define CSQ_ST_TEMP_OK 12
`define CSQ_ST_TEMP_HOT 13
`define CSQ_ST_MEAS 14
`define CSQ_ST_IND_OE 15

// Indicator vector bit positions and idle value.
`define CSQ_IND_CC 0
`define CSQ_IND_CV 1
`define CSQ_IND_FAULT 2
`define CSQ_IND_IDLE 3'h7

`endif

/* File: pkg/csq_pkg.sv */
package csq_pkg;

  // Charging states.
  typedef enum logic [2:0] {
    CSQ_RESET  = 3'b000,
    CSQ_QUAL   = 3'b001,
    CSQ_FAST   = 3'b010,
    CSQ_FULL   = 3'b011,
    CSQ_TOPOFF = 3'b100,
    CSQ_DONE   = 3'b101,
    CSQ_PAUSE  = 3'b110,
    CSQ_FAULT  = 3'b111
  } csq_state_t;

  // Analog comparator results, all active high.
  typedef struct packed {
    logic supply_ok;
    logic ref_ok;
    logic bias_ok;
    logic above_uv;
    logic at_reg;
    logic below_recharge;
    logic over_voltage;
    logic dropout;
    logic below_term_current;
    logic temp_in_window;
    logic temp_at_max;
  } csq_cmp_t;

endpackage

/* File: hdl/csq_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module csq_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } csq_sync_regs_t;

  csq_sync_regs_t r_q;
  csq_sync_regs_t r_d;

  // A bit moves on only when the second and third stages agree, which
  // filters a single metastable resolution; the first stage feeds only s2.
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.q[i] = r_q.s3[i];
      end
    end
    if (!rst_n) begin
      r_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  assign q = r_q.q;

endmodule

`default_nettype wire

/* File: hdl/csq_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module csq_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  typedef struct packed {
    logic [W-1:0] count;
  } csq_tmr_regs_t;

  csq_tmr_regs_t r_q;
  csq_tmr_regs_t r_d;

  // Clear wins over counting; with run low the count is frozen, so a
  // paused phase picks up where it stopped.
  always_comb begin
    r_d = r_q;
    if (!rst_n || clear) begin
      r_d.count = '0;
    end else if (run && tick && !expired) begin
      r_d.count = r_q.count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  assign expired = (r_q.count >= limit);

endmodule

`default_nettype wire

/* File: hdl/csq_charge_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csq_consts.svh"

// What this block does
// - Power-up or leaving power-down enters reset and zeroes both timers.
// - Dropout or battery overvoltage returns the sequencer to reset from any state but fault.
// - Reset holds current at zero with all three indicators released high.
// - Reset exits to qualification only when supply, reference, bias are good.
// - Qualification requests a tenth of fast current, constant-current lamp on.
// - Qualification timeout without leaving undervoltage goes to fault.
// - Qualification moves to fast charge above undervoltage with temperature ok.
// - Fast charge requests full current, constant-current lamp on, timer B.
// - Reaching regulation voltage in fast charge moves to full charge.
// - Fast-charge timer expiry before regulation voltage goes to fault.
// - Full charge regulates voltage, constant-voltage lamp on, timer A.
// - Low charge current or full-charge timeout moves to top-off.
// - Top-off keeps voltage mode, lamps off, done when timer A expires.
// - Done gives zero current, returns to reset below recharge threshold.
// - Temperature out of window pauses charging, freezes timers, keeps lamps.
// - Temperature back in window resumes interrupted state with held count.
// - Reset goes straight to fault when the battery is too hot.
// - Fault gives zero current, fault lamp on, both phase lamps off.
// - Fault is left only by power cycle or the power-down input.
// - Power-down stops charging and floats all three indicator outputs.
// - Temperature sampled about 1.12 Hz, charging briefly paused to measure.
module csq_charge_sequencer
  import csq_pkg::*;
#(
  parameter int          PRESCALE   = `CSQ_PRESCALE_CYC,
  parameter int          TEMP_TICKS = `CSQ_TEMP_PERIOD_TICKS,
  parameter int          TW         = 24,
  parameter logic [23:0] QUAL_TICKS = 24'(`CSQ_QUAL_TICKS),
  parameter logic [23:0] FULL_TICKS = 24'(`CSQ_FULL_TICKS),
  parameter logic [23:0] TOP_TICKS  = 24'(`CSQ_TOP_TICKS),
  parameter logic [23:0] FAST_TICKS = 24'(`CSQ_FAST_TICKS)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire csq_cmp_t    cmp,
  input  wire logic        power_down_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [7:0]  charge_current_setpoint,
  output logic             charge_enable,
  output logic             const_voltage_mode,
  output logic             temp_measure,
  output logic             const_current_indicator_n,
  output logic             const_current_indicator_oe,
  output logic             const_voltage_indicator_n,
  output logic             const_voltage_indicator_oe,
  output logic             fault_indicator_n,
  output logic             fault_indicator_oe
);

  localparam int PW  = $clog2(PRESCALE);
  localparam int TPW = $clog2(TEMP_TICKS + 1);
  localparam int SW  = $bits(csq_cmp_t) + 1;

  typedef struct packed {
    csq_state_t       st;
    csq_state_t       resume;
    logic [PW-1:0]    pre;
    logic             tick;
    logic [TPW-1:0]   tper;
    logic             meas;
    logic             temp_valid;
    logic             temp_ok;
    logic             temp_hot;
    logic [7:0]       fast_i;
    logic [TW-1:0]    lim_qual;
    logic [TW-1:0]    lim_full;
    logic [TW-1:0]    lim_top;
    logic [TW-1:0]    lim_fast;
    logic             wait_q;
    logic [31:0]      rdata;
    logic [7:0]       setpoint;
    logic             chg_en;
    logic             cv_mode;
    logic [2:0]       ind_n;
    logic             ind_oe;
  } csq_regs_t;

  csq_regs_t    r_q;
  csq_regs_t    r_d;
  logic [SW-1:0] sync_q;
  csq_cmp_t     cmp_s;
  logic         pd_n_s;
  logic         clr_a;
  logic         clr_b;
  logic         run_a;
  logic         run_b;
  logic         exp_a;
  logic         exp_b;
  logic [TW-1:0] lim_a;

  // Indicator levels for a state, bit order {fault, cv, cc}.
  function automatic logic [2:0] ind_for(csq_state_t s, logic [2:0] hold);
    logic [2:0] v;
    v = `CSQ_IND_IDLE;
    case (s)
      CSQ_QUAL, CSQ_FAST: v[`CSQ_IND_CC] = 1'b0;
      CSQ_FULL:           v[`CSQ_IND_CV] = 1'b0;
      CSQ_FAULT:          v[`CSQ_IND_FAULT] = 1'b0;
      CSQ_PAUSE:          v = hold;
      default:            v = `CSQ_IND_IDLE;
    endcase
    return v;
  endfunction

  // Current request for a state; the voltage loop caps it in CV phases.
  function automatic logic [7:0] setpt_for(csq_state_t s, logic [7:0] fi);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      CSQ_QUAL:                     v = 8'(fi / `CSQ_PRECHG_DIV);
      CSQ_FAST, CSQ_FULL, CSQ_TOPOFF: v = fi;
      default:                      v = 8'h00;
    endcase
    return v;
  endfunction

  // States timed by timer A.
  function automatic logic uses_a(csq_state_t s);
    return (s == CSQ_QUAL) || (s == CSQ_FULL) || (s == CSQ_TOPOFF);
  endfunction

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] wd,
                                        logic [3:0]  be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // Comparators and the power-down pin arrive from the analog side.
  csq_sync #(
    .W (SW)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({power_down_n, cmp}),
    .q     (sync_q)
  );

  assign cmp_s  = sync_q[SW-2:0];
  assign pd_n_s = sync_q[SW-1];

  // Timer A serves qualification, full charge and top-off in turn.
  always_comb begin
    case (r_q.st)
      CSQ_QUAL: lim_a = r_q.lim_qual;
      CSQ_FULL: lim_a = r_q.lim_full;
      default:  lim_a = r_q.lim_top;
    endcase
  end

  // Pause freezes both timers because the state leaves the timed set.
  assign run_a = uses_a(r_q.st);
  assign run_b = (r_q.st == CSQ_FAST);

  csq_timer #(
    .W (TW)
  ) u_phase_timer_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (clr_a),
    .run     (run_a),
    .tick    (r_q.tick),
    .limit   (lim_a),
    .expired (exp_a)
  );

  csq_timer #(
    .W (TW)
  ) u_phase_timer_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (clr_b),
    .run     (run_b),
    .tick    (r_q.tick),
    .limit   (r_q.lim_fast),
    .expired (exp_b)
  );

  // Next-state logic for the whole block, including the bus slave.
  always_comb begin
    r_d   = r_q;
    clr_a = 1'b0;
    clr_b = 1'b0;

    // Millisecond tick from the system clock.
    r_d.tick = (r_q.pre == PW'(PRESCALE - 1));
    r_d.pre  = r_d.tick ? '0 : r_q.pre + 1'b1;

    // Thermistor sampling: results are taken at the end of the window,
    // since the sense currents are only settled by then.
    if (r_q.tick) begin
      if (r_q.tper == TPW'(TEMP_TICKS - 1)) begin
        r_d.tper = '0;
      end else begin
        r_d.tper = r_q.tper + 1'b1;
      end
      if (r_q.tper == TPW'(`CSQ_TEMP_MEAS_TICKS - 1)) begin
        r_d.temp_valid = 1'b1;
        r_d.temp_ok    = cmp_s.temp_in_window;
        r_d.temp_hot   = cmp_s.temp_at_max;
      end
    end
    r_d.meas = (r_d.tper < TPW'(`CSQ_TEMP_MEAS_TICKS));

    // Charging state machine.
    if (!pd_n_s) begin
      r_d.st = CSQ_RESET;
    end else begin
      case (r_q.st)
        CSQ_RESET: begin
          if (cmp_s.supply_ok && cmp_s.ref_ok && cmp_s.bias_ok &&
              !cmp_s.dropout && !cmp_s.over_voltage &&
              r_q.temp_valid) begin
            if (r_q.temp_hot) begin
              r_d.st = CSQ_FAULT;
            end else begin
              r_d.st = CSQ_QUAL;
            end
          end
        end
        CSQ_QUAL: begin
          if (!r_q.temp_ok) begin
            r_d.st     = CSQ_PAUSE;
            r_d.resume = CSQ_QUAL;
          end else if (cmp_s.above_uv) begin
            r_d.st = CSQ_FAST;
          end else if (exp_a) begin
            r_d.st = CSQ_FAULT;
          end
        end
        CSQ_FAST: begin
          if (!r_q.temp_ok) begin
            r_d.st     = CSQ_PAUSE;
            r_d.resume = CSQ_FAST;
          end else if (cmp_s.at_reg) begin
            r_d.st = CSQ_FULL;
          end else if (exp_b) begin
            r_d.st = CSQ_FAULT;
          end
        end
        CSQ_FULL: begin
          if (!r_q.temp_ok) begin
            r_d.st     = CSQ_PAUSE;
            r_d.resume = CSQ_FULL;
          end else if (cmp_s.below_term_current || exp_a) begin
            r_d.st = CSQ_TOPOFF;
          end
        end
        CSQ_TOPOFF: begin
          if (!r_q.temp_ok) begin
            r_d.st     = CSQ_PAUSE;
            r_d.resume = CSQ_TOPOFF;
          end else if (exp_a) begin
            r_d.st = CSQ_DONE;
          end
        end
        CSQ_DONE: begin
          if (cmp_s.below_recharge) begin
            r_d.st = CSQ_RESET;
          end
        end
        CSQ_PAUSE: begin
          if (r_q.temp_ok) begin
            r_d.st = r_q.resume;
          end
        end
        default: begin
          r_d.st = CSQ_FAULT;
        end
      endcase
      // Loss of headroom or overvoltage restarts any live phase.
      if (r_q.st != CSQ_FAULT && r_q.st != CSQ_RESET &&
          (cmp_s.dropout || cmp_s.over_voltage)) begin
        r_d.st = CSQ_RESET;
      end
    end

    // Timers restart on entry to a phase but not on return from a pause.
    if (r_q.st == CSQ_RESET) begin
      clr_a = 1'b1;
      clr_b = 1'b1;
    end else if (r_d.st != r_q.st && r_q.st != CSQ_PAUSE) begin
      clr_a = uses_a(r_d.st);
      clr_b = (r_d.st == CSQ_FAST);
    end

    // Outputs follow the next state so they line up with it.
    r_d.setpoint = setpt_for(r_d.st, r_q.fast_i);
    r_d.chg_en   = (r_d.setpoint != 8'h00) && !r_d.meas;
    if (r_d.meas) begin
      r_d.setpoint = 8'h00;
    end
    r_d.cv_mode = (r_d.st == CSQ_FULL) || (r_d.st == CSQ_TOPOFF);
    r_d.ind_n   = ind_for(r_d.st, r_q.ind_n);
    r_d.ind_oe  = pd_n_s;

    // Avalon slave: answer one cycle after the request, for one cycle.
    if ((avs_read || avs_write) && r_q.wait_q) begin
      r_d.wait_q = 1'b0;
      r_d.rdata  = 32'h0000_0000;
      if (avs_address == `CSQ_ADDR_STATUS) begin
        r_d.rdata[`CSQ_ST_STATE_LSB +: 3]  = r_q.st;
        r_d.rdata[`CSQ_ST_RESUME_LSB +: 3] = r_q.resume;
        r_d.rdata[`CSQ_ST_IND_LSB +: 3]    = r_q.ind_n;
        r_d.rdata[`CSQ_ST_TEMP_OK]         = r_q.temp_ok;
        r_d.rdata[`CSQ_ST_TEMP_HOT]        = r_q.temp_hot;
        r_d.rdata[`CSQ_ST_MEAS]            = r_q.meas;
        r_d.rdata[`CSQ_ST_IND_OE]          = r_q.ind_oe;
      end else if (avs_address == `CSQ_ADDR_FAST_I) begin
        r_d.rdata[7:0] = r_q.fast_i;
      end else if (avs_address == `CSQ_ADDR_LIM_QUAL) begin
        r_d.rdata[TW-1:0] = r_q.lim_qual;
      end else if (avs_address == `CSQ_ADDR_LIM_FULL) begin
        r_d.rdata[TW-1:0] = r_q.lim_full;
      end else if (avs_address == `CSQ_ADDR_LIM_TOP) begin
        r_d.rdata[TW-1:0] = r_q.lim_top;
      end else if (avs_address == `CSQ_ADDR_LIM_FAST) begin
        r_d.rdata[TW-1:0] = r_q.lim_fast;
      end
    end else begin
      r_d.wait_q = 1'b1;
    end

    // Writes land at the edge where the master sees waitrequest low.
    if (avs_write && !r_q.wait_q) begin
      if (avs_address == `CSQ_ADDR_FAST_I) begin
        r_d.fast_i = 8'(merge({24'h0, r_q.fast_i}, avs_writedata,
                              avs_byteenable));
      end else if (avs_address == `CSQ_ADDR_LIM_QUAL) begin
        r_d.lim_qual = TW'(merge(32'(r_q.lim_qual), avs_writedata,
                                 avs_byteenable));
      end else if (avs_address == `CSQ_ADDR_LIM_FULL) begin
        r_d.lim_full = TW'(merge(32'(r_q.lim_full), avs_writedata,
                                 avs_byteenable));
      end else if (avs_address == `CSQ_ADDR_LIM_TOP) begin
        r_d.lim_top = TW'(merge(32'(r_q.lim_top), avs_writedata,
                                avs_byteenable));
      end else if (avs_address == `CSQ_ADDR_LIM_FAST) begin
        r_d.lim_fast = TW'(merge(32'(r_q.lim_fast), avs_writedata,
                                 avs_byteenable));
      end
    end

    // Synchronous reset; the phase lamps start released.
    if (!rst_n) begin
      r_d          = '0;
      r_d.st       = CSQ_RESET;
      r_d.resume   = CSQ_RESET;
      r_d.fast_i   = `CSQ_FAST_I_RST;
      r_d.lim_qual = QUAL_TICKS;
      r_d.lim_full = FULL_TICKS;
      r_d.lim_top  = TOP_TICKS;
      r_d.lim_fast = FAST_TICKS;
      r_d.wait_q   = 1'b1;
      r_d.ind_n    = `CSQ_IND_IDLE;
      r_d.meas     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  // Every output is a field of the state register.
  assign avs_readdata               = r_q.rdata;
  assign avs_waitrequest            = r_q.wait_q;
  assign charge_current_setpoint    = r_q.setpoint;
  assign charge_enable              = r_q.chg_en;
  assign const_voltage_mode         = r_q.cv_mode;
  assign temp_measure               = r_q.meas;
  assign const_current_indicator_n  = r_q.ind_n[`CSQ_IND_CC];
  assign const_current_indicator_oe = r_q.ind_oe;
  assign const_voltage_indicator_n  = r_q.ind_n[`CSQ_IND_CV];
  assign const_voltage_indicator_oe = r_q.ind_oe;
  assign fault_indicator_n          = r_q.ind_n[`CSQ_IND_FAULT];
  assign fault_indicator_oe         = r_q.ind_oe;

endmodule

`default_nettype wire

/* File: verif/csq_charge_sequencer_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin-level checks on the sequencer; it sees only the top-level ports.
module csq_charge_sequencer_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       power_down_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [7:0] charge_current_setpoint,
  input wire logic       charge_enable,
  input wire logic       const_voltage_mode,
  input wire logic       temp_measure,
  input wire logic       const_current_indicator_n,
  input wire logic       const_current_indicator_oe,
  input wire logic       const_voltage_indicator_n,
  input wire logic       const_voltage_indicator_oe,
  input wire logic       fault_indicator_n,
  input wire logic       fault_indicator_oe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  fault_lamp_excl_a: assert property (
    !fault_indicator_n |-> const_current_indicator_n &&
    const_voltage_indicator_n && charge_current_setpoint == 8'h00)
    else $error("fault lamp lit with phase lamp or current");
  phase_lamp_excl_a: assert property (
    !const_voltage_indicator_n |-> const_current_indicator_n &&
    fault_indicator_n) else $error("voltage lamp lit with another lamp");
  voltage_mode_a: assert property (
    const_voltage_mode |-> const_current_indicator_n && fault_indicator_n)
    else $error("voltage mode with current or fault lamp");
  measure_gate_a: assert property (
    temp_measure |-> !charge_enable && charge_current_setpoint == 8'h00)
    else $error("charging during temperature measurement");
  // Three sync flops, agreement and the output register fit in six cycles.
  pdown_float_a: assert property (
    !power_down_n [*6] |=> !const_current_indicator_oe &&
    !const_voltage_indicator_oe && !fault_indicator_oe && !charge_enable)
    else $error("outputs still active in power-down");
  fault_hold_a: assert property (
    !fault_indicator_n && power_down_n |=> $stable(fault_indicator_n))
    else $error("fault left without power-down");
  wait_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

bind csq_charge_sequencer csq_charge_sequencer_chk chk (
  .clk(clk), .rst_n(rst_n), .power_down_n(power_down_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .charge_current_setpoint(charge_current_setpoint),
  .charge_enable(charge_enable), .const_voltage_mode(const_voltage_mode),
  .temp_measure(temp_measure),
  .const_current_indicator_n(const_current_indicator_n),
  .const_current_indicator_oe(const_current_indicator_oe),
  .const_voltage_indicator_n(const_voltage_indicator_n),
  .const_voltage_indicator_oe(const_voltage_indicator_oe),
  .fault_indicator_n(fault_indicator_n),
  .fault_indicator_oe(fault_indicator_oe)
);

`default_nettype wire

/* File: verif/csq_batt_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Cell, comparators and lamp pull-ups. env: power good, temp ok, hot,
// dropout, discharge, then a two-bit cell kind (1 dead, 2 weak).
module csq_batt_model
  import csq_pkg::*;
#(
  parameter int UV  = 40,
  parameter int REG = 300
) (
  input  wire logic       clk,
  input  wire logic       charge_enable,
  input  wire logic       const_voltage_mode,
  input  wire logic [6:0] env,
  input  wire logic [2:0] ind_n,
  input  wire logic [2:0] ind_oe,
  output var  csq_cmp_t   cmp,
  output logic      [2:0] lamps
);
  int volt = 0;
  int cv_cyc = 0;

  // A weak cell stalls short of regulation, so only a timer can end it.
  always @(posedge clk) begin
    if (env[4]) begin
      volt <= 0;
    end else if (charge_enable && env[6:5] != 2'd1 &&
                 volt < (env[6] ? REG - 50 : REG)) begin
      volt <= volt + 1;
    end
    cv_cyc <= const_voltage_mode ? cv_cyc + 1 : 0;
  end

  // Current tapers once the cell has sat in voltage mode for a while.
  assign cmp = '{env[0], env[0], env[0], volt > UV, volt >= REG,
                 volt < REG - 20, 1'b0, env[3], cv_cyc > 100,
                 env[1] && !env[2], env[2]};
  // Released open-drain pins read high through their pull-ups.
  assign lamps = ind_n | ~ind_oe;
endmodule

`default_nettype wire

/* File: verif/tb_csq_charge_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end

module tb_csq_charge_sequencer
  import csq_pkg::*;
;
  localparam logic [23:0] LQ = 24'd40;
  localparam logic [23:0] LT = 24'd20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        power_down_n = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [6:0]  env = 7'h13;
  logic [7:0]  fi = 8'hff;
  logic [31:0] rd;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 84249;
  wire csq_cmp_t    cmp;
  wire logic [31:0] avs_readdata;
  wire logic [7:0]  charge_current_setpoint;
  wire logic [2:0]  ind_n, ind_oe, lamps;
  wire logic avs_waitrequest, charge_enable, const_voltage_mode, temp_measure;

  csq_charge_sequencer #(
    .PRESCALE(4), .TEMP_TICKS(8), .QUAL_TICKS(LQ), .FULL_TICKS(24'd200),
    .TOP_TICKS(LT), .FAST_TICKS(24'd200)
  ) uut (
    .clk(clk), .rst_n(rst_n), .cmp(cmp), .power_down_n(power_down_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .charge_current_setpoint(charge_current_setpoint),
    .charge_enable(charge_enable), .const_voltage_mode(const_voltage_mode),
    .temp_measure(temp_measure), .const_current_indicator_n(ind_n[0]),
    .const_current_indicator_oe(ind_oe[0]),
    .const_voltage_indicator_n(ind_n[1]),
    .const_voltage_indicator_oe(ind_oe[1]),
    .fault_indicator_n(ind_n[2]), .fault_indicator_oe(ind_oe[2])
  );

  csq_batt_model model (
    .clk(clk), .charge_enable(charge_enable),
    .const_voltage_mode(const_voltage_mode), .env(env), .ind_n(ind_n),
    .ind_oe(ind_oe), .cmp(cmp), .lamps(lamps)
  );

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A wait that runs out is a mismatch and ends the run.
  task automatic give_up();
    errors++;
    end_of_test();
  endtask

  // One access, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Registered outputs read here still hold their pre-edge values.
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) give_up();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Lamp pins {fault, cv, cc} and current code expected in each state.
  function automatic logic [10:0] exp_out(input csq_state_t s);
    case (s)
      CSQ_QUAL: return {3'b110, fi / 8'd10};
      CSQ_FAST: return {3'b110, fi};
      CSQ_FULL: return {3'b101, fi};
      CSQ_TOPOFF: return {3'b111, fi};
      CSQ_FAULT: return {3'b011, 8'h00};
      CSQ_PAUSE: return {3'b110, 8'h00}; // Only fast charge is paused here.
      default: return {3'b111, 8'h00};
    endcase
  endfunction

  // Poll status until the state shows, then compare outside measurement.
  task automatic expect_st(input csq_state_t s);
    int n;
    logic [10:0] e;
    logic [12:0] g;
    n = 0;
    e = exp_out(s);
    do begin
      bus(1'b0, 5'h00);
      n++;
    end while (rd[2:0] !== s && n < 1500);
    if (n >= 1500) give_up();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (temp_measure !== 1'b0 && n < 100);
    if (n >= 100) give_up();
    g = {lamps, charge_current_setpoint, charge_enable, const_voltage_mode};
    `CHK(g, {e, e[7:0] != 8'h00, s == CSQ_FULL || s == CSQ_TOPOFF})
    @(posedge clk);
  endtask

  // Hold power-down past the synchroniser with the cell drained, release.
  task automatic restart(input logic [6:0] e);
    power_down_n <= 1'b0;
    env <= e | 7'h10;
    // Long enough for the latched temperature to see the new level.
    repeat (40) @(posedge clk);
    `CHK({ind_oe, lamps, charge_enable}, 7'h0e)
    power_down_n <= 1'b1;
    env <= e;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h04);
    `CHK(rd, 32'h0000_00ff)
    bus(1'b0, 5'h08);
    `CHK(rd, {8'h00, LQ})
    bus(1'b1, 5'h10, 32'hffff_ffff);
    bus(1'b0, 5'h10);
    `CHK(rd, 32'h00ff_ffff)
    avs_byteenable <= 4'h3;
    bus(1'b1, 5'h10, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b0, 5'h10);
    `CHK(rd, 32'h00ff_0000)
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    bus(1'b0, 5'h1c);
    `CHK(rd, 32'h0)
    bus(1'b1, 5'h10, {8'h00, LT});
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      fi = 8'($random(seed)) | 8'h10;
      bus(1'b1, 5'h04, {24'h0, fi});
      restart(7'h03);
      expect_st(CSQ_QUAL);
      expect_st(CSQ_FAST);
      expect_st(CSQ_FULL);
      `CHK(const_voltage_mode, 1'b1)
      expect_st(CSQ_TOPOFF);
      expect_st(CSQ_DONE);
      env <= 7'h13;
      expect_st(CSQ_QUAL);
      $display("test charge cycle %0d done", i);
    end
    restart(7'h03);
    expect_st(CSQ_FAST);
    repeat ($random(seed) & 63) @(posedge clk);
    env <= 7'h01;
    expect_st(CSQ_PAUSE);
    `CHK(lamps, 3'b110)
    `CHK(rd[6:4], 3'b010)
    env <= 7'h03;
    expect_st(CSQ_FAST);
    env <= 7'h0a;
    expect_st(CSQ_RESET);
    $display("test pause and dropout done");
    restart(7'h43);
    bus(1'b1, 5'h14, 32'd30);
    bus(1'b0, 5'h14);
    `CHK(rd, 32'd30)
    expect_st(CSQ_FAST);
    expect_st(CSQ_FAULT);
    $display("test fast timeout done");
    restart(7'h23);
    expect_st(CSQ_QUAL);
    expect_st(CSQ_FAULT);
    env <= 7'h03;
    repeat (100) @(posedge clk);
    expect_st(CSQ_FAULT);
    restart(7'h03);
    expect_st(CSQ_QUAL);
    $display("test qualification timeout done");
    restart(7'h07);
    expect_st(CSQ_FAULT);
    $display("test hot battery done");
    end_of_test();
  end
endmodule

`default_nettype wire
